//--- core/sllc_consts.vh
// Purpose: Shared constants of the serial latched low-side control block
// Assumes: 100 MHz system clock
// Notes:   Times are kept in their own unit; cycle counts derive from them
`ifndef SLLC_CONSTS_VH
`define SLLC_CONSTS_VH

`define SLLC_CLK_MHZ          100
`define SLLC_CHANNELS         8
`define SLLC_FIFO_DEPTH       4
`define SLLC_FIFO_AW          2

// Overcurrent deglitch, least time, rounded up to whole cycles
`define SLLC_OCP_DEGLITCH_NS  3500
`define SLLC_OCP_DEGLITCH_CYC ((`SLLC_OCP_DEGLITCH_NS * `SLLC_CLK_MHZ + 999) / 1000)
// Overcurrent retry time
`define SLLC_OCP_RETRY_US     2500
`define SLLC_OCP_RETRY_CYC    (`SLLC_OCP_RETRY_US * `SLLC_CLK_MHZ)
`define SLLC_CNT_W            18

// Reset values
`define SLLC_SHIFT_RST        8'h00
`define SLLC_LATCH_RST        8'h00
`define SLLC_SYNC_RST         16'h8000

// Bit positions inside the synchronised input vector
`define SLLC_IN_OC_LSB        0
`define SLLC_IN_SCK           8
`define SLLC_IN_SDI           9
`define SLLC_IN_LATCH         10
`define SLLC_IN_RESET         11
`define SLLC_IN_OE            12
`define SLLC_IN_OT            13
`define SLLC_IN_UV            14
`define SLLC_IN_CS_N          15
`define SLLC_IN_W             16

`endif

//--- core/sllc_fifo.v
// Purpose: Small synchronous FIFO between latch capture and output latch
// Assumes: Single clock; flush empties it at once
// Notes:   in_ready low when full, out_valid low when empty
`timescale 1ns/1ps
module sllc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clock,
  input  wire             rstn,
  input  wire             flush,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_q;
  reg  [AW-1:0]    rd_ptr_q;
  reg  [AW:0]      count_q;
  wire             push;
  wire             pop;

  assign in_ready  = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_q <= count_q + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_q <= count_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule // sllc_fifo

//--- core/sllc_sync.v
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs are asynchronous to clock
// Notes:   Output changes only once stages two and three agree
`timescale 1ns/1ps
module sllc_sync #(
  parameter             WIDTH     = 16,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input  wire             clock,
  input  wire             rstn,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] stable_q
);

  reg  [WIDTH-1:0] ff1_q;
  reg  [WIDTH-1:0] ff2_q;
  reg  [WIDTH-1:0] ff3_q;
  wire [WIDTH-1:0] agree;

  assign agree = ~(ff2_q ^ ff3_q);

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ff1_q    <= RESET_VAL;
      ff2_q    <= RESET_VAL;
      ff3_q    <= RESET_VAL;
      stable_q <= RESET_VAL;
    end else begin
      ff1_q    <= async_in;
      ff2_q    <= ff1_q;
      ff3_q    <= ff2_q;
      stable_q <= (ff3_q & agree) | (stable_q & ~agree);
    end
  end

endmodule // sllc_sync

//--- core/sllc_top.v
// Purpose: Serial latched control of an eight-channel low-side driver
// Assumes: All control and fault input pins are asynchronous and sampled by the 100 MHz clock
// Notes:   Open-drain pins are split into input, output and output enable
`timescale 1ns/1ps
`include "sllc_consts.vh"

module sllc_top #(
  parameter [`SLLC_CNT_W-1:0] RETRY_CYCLES = `SLLC_OCP_RETRY_CYC
) (
  input  wire                      clock,
  input  wire                      rstn,
  input  wire                      shift_clock,
  input  wire                      serial_data_in,
  input  wire                      chip_select_n,
  input  wire                      latch_pin,
  input  wire                      reset_pin,
  input  wire                      output_enable_pin,
  input  wire [`SLLC_CHANNELS-1:0] overcurrent_trip,
  input  wire                      over_temp,
  input  wire                      undervoltage_lock,
  input  wire                      serial_data_out_i,
  output reg                       serial_data_out_o,
  output reg                       serial_data_out_oe,
  input  wire                      fault_flag_n_i,
  output reg                       fault_flag_n_o,
  output reg                       fault_flag_n_oe,
  output wire [`SLLC_CHANNELS-1:0] drive_output
);

  // The header count is a 32-bit integer; only its low bits are kept
  localparam integer           DEGLITCH_INT    = `SLLC_OCP_DEGLITCH_CYC;
  localparam [`SLLC_CNT_W-1:0] DEGLITCH_CYCLES = DEGLITCH_INT[`SLLC_CNT_W-1:0];
  localparam [`SLLC_CNT_W-1:0] CNT_ONE         = 18'h0_0001;

  localparam [1:0] OCP_RUN      = 2'h0;
  localparam [1:0] OCP_DEGLITCH = 2'h1;
  localparam [1:0] OCP_SHUT     = 2'h2;

  // Rising and falling edges of a filtered level
  function rise;
    input prev;
    input now;
    begin
      rise = now & ~prev;
    end
  endfunction

  function fall;
    input prev;
    input now;
    begin
      fall = prev & ~now;
    end
  endfunction

  wire [`SLLC_IN_W-1:0]     pins_async;
  wire [`SLLC_IN_W-1:0]     pins_s;
  wire [`SLLC_CHANNELS-1:0] oc_s;
  wire                      sck_s;
  wire                      sdi_s;
  wire                      latch_s;
  wire                      reset_s;
  wire                      oe_s;
  wire                      ot_s;
  wire                      uv_s;
  wire                      cs_n_s;
  wire                      logic_rst;
  wire                      sck_rise;
  wire                      sck_fall;
  wire                      latch_rise;
  wire                      cs_fall;
  wire                      fifo_in_ready;
  wire                      fifo_out_valid;
  wire                      fifo_out_ready;
  wire [`SLLC_CHANNELS-1:0] fifo_out_data;
  wire                      fifo_push;
  wire                      oc_active;
  wire                      ocp_shut;
  wire                      drive_allow;
  wire                      shutdown;
  wire [`SLLC_CHANNELS-1:0] oc_hit;

  reg                       sck_prev_q;
  reg                       latch_prev_q;
  reg                       cs_n_prev_q;
  reg  [`SLLC_CHANNELS-1:0] shift_q;
  reg  [`SLLC_CHANNELS-1:0] shift_d;
  reg  [`SLLC_CHANNELS-1:0] latch_q;
  reg  [`SLLC_CHANNELS-1:0] latch_d;
  reg  [`SLLC_CHANNELS-1:0] drive_q;
  reg                       sdo_bit_q;
  reg                       sdo_bit_d;
  reg                       sdo_oe_d;
  reg                       fault_oe_d;
  reg  [1:0]                ocp_state_q;
  reg  [1:0]                ocp_state_d;
  reg  [`SLLC_CNT_W-1:0]    ocp_cnt_q;
  reg  [`SLLC_CNT_W-1:0]    ocp_cnt_d;

  // All control and fault input pins pass the three-stage filter; chip select idles high
  assign pins_async = {chip_select_n, undervoltage_lock, over_temp, output_enable_pin,
                       reset_pin, latch_pin, serial_data_in, shift_clock, overcurrent_trip};

  sllc_sync #(
    .WIDTH     (`SLLC_IN_W),
    .RESET_VAL (`SLLC_SYNC_RST)
  ) u_sync (
    .clock    (clock),
    .rstn     (rstn),
    .async_in (pins_async),
    .stable_q (pins_s)
  );

  assign oc_s    = pins_s[`SLLC_IN_OC_LSB +: `SLLC_CHANNELS];
  assign sck_s   = pins_s[`SLLC_IN_SCK];
  assign sdi_s   = pins_s[`SLLC_IN_SDI];
  assign latch_s = pins_s[`SLLC_IN_LATCH];
  assign reset_s = pins_s[`SLLC_IN_RESET];
  assign oe_s    = pins_s[`SLLC_IN_OE];
  assign ot_s    = pins_s[`SLLC_IN_OT];
  assign uv_s    = pins_s[`SLLC_IN_UV];
  assign cs_n_s  = pins_s[`SLLC_IN_CS_N];

  // Reset pin or undervoltage hold the shift, serial out, queue, latch, overcurrent state and drives in their initial values
  assign logic_rst = reset_s | uv_s;

  assign sck_rise   = rise(sck_prev_q, sck_s);
  assign sck_fall   = fall(sck_prev_q, sck_s);
  assign latch_rise = rise(latch_prev_q, latch_s);
  assign cs_fall    = fall(cs_n_prev_q, cs_n_s);

  // Reset values equal the idle pin levels, so no false edge follows reset
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sck_prev_q   <= 1'b0;
      latch_prev_q <= 1'b0;
      cs_n_prev_q  <= 1'b1;
    end else begin
      sck_prev_q   <= sck_s;
      latch_prev_q <= latch_s;
      cs_n_prev_q  <= cs_n_s;
    end
  end

  // Shift register: sampled on shift clock rise while selected, whatever the enable
  always @* begin
    shift_d = shift_q;
    if (logic_rst) begin
      shift_d = `SLLC_SHIFT_RST;
    end else if (sck_rise && !cs_n_s) begin
      shift_d = {shift_q[`SLLC_CHANNELS-2:0], sdi_s};
    end
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shift_q <= `SLLC_SHIFT_RST;
    end else begin
      shift_q <= shift_d;
    end
  end

  // Oldest bit is presented at select and after each falling edge
  always @* begin
    sdo_bit_d = sdo_bit_q;
    if (logic_rst) begin
      sdo_bit_d = 1'b1;
    end else if (cs_fall || (sck_fall && !cs_n_s)) begin
      sdo_bit_d = shift_q[`SLLC_CHANNELS-1];
    end
  end

  // Open drain: pull low only for a zero while selected and out of reset
  always @* begin
    sdo_oe_d = 1'b0;
    if (!logic_rst && !cs_n_s) begin
      sdo_oe_d = ~sdo_bit_d;
    end
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sdo_bit_q          <= 1'b1;
      serial_data_out_o  <= 1'b0;
      serial_data_out_oe <= 1'b0;
    end else begin
      sdo_bit_q          <= sdo_bit_d;
      serial_data_out_o  <= 1'b0;
      serial_data_out_oe <= sdo_oe_d;
    end
  end

  // Latch edges queue their word; a word taken while the queue is full is lost
  assign fifo_push      = latch_rise & ~logic_rst;
  // Queued words reach the output latch only between transfers
  assign fifo_out_ready = cs_n_s & ~logic_rst;

  sllc_fifo #(
    .WIDTH (`SLLC_CHANNELS),
    .DEPTH (`SLLC_FIFO_DEPTH),
    .AW    (`SLLC_FIFO_AW)
  ) u_fifo (
    .clock     (clock),
    .rstn      (rstn),
    .flush     (logic_rst),
    .in_data   (shift_q),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready)
  );

  always @* begin
    latch_d = latch_q;
    if (logic_rst) begin
      latch_d = `SLLC_LATCH_RST;
    end else if (fifo_out_valid && fifo_out_ready) begin
      latch_d = fifo_out_data;
    end
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      latch_q <= `SLLC_LATCH_RST;
    end else begin
      latch_q <= latch_d;
    end
  end

  // Overcurrent: only a driven channel can carry current
  assign oc_active = |oc_hit;
  assign ocp_shut  = (ocp_state_q == OCP_SHUT);

  always @* begin
    ocp_state_d = ocp_state_q;
    ocp_cnt_d   = ocp_cnt_q;
    case (ocp_state_q)
      OCP_RUN: begin
        ocp_cnt_d = {`SLLC_CNT_W{1'b0}};
        if (oc_active) begin
          ocp_state_d = OCP_DEGLITCH;
          ocp_cnt_d   = CNT_ONE;
        end
      end
      OCP_DEGLITCH: begin
        if (!oc_active) begin
          ocp_state_d = OCP_RUN;
          ocp_cnt_d   = {`SLLC_CNT_W{1'b0}};
        end else if (ocp_cnt_q >= DEGLITCH_CYCLES) begin
          ocp_state_d = OCP_SHUT;
          ocp_cnt_d   = CNT_ONE;
        end else begin
          ocp_cnt_d = ocp_cnt_q + CNT_ONE;
        end
      end
      OCP_SHUT: begin
        if (ocp_cnt_q >= RETRY_CYCLES) begin
          ocp_state_d = OCP_RUN;
          ocp_cnt_d   = {`SLLC_CNT_W{1'b0}};
        end else begin
          ocp_cnt_d = ocp_cnt_q + CNT_ONE;
        end
      end
      default: begin
        ocp_state_d = OCP_RUN;
        ocp_cnt_d   = {`SLLC_CNT_W{1'b0}};
      end
    endcase
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ocp_state_q <= OCP_RUN;
      ocp_cnt_q   <= {`SLLC_CNT_W{1'b0}};
    end else if (logic_rst) begin
      ocp_state_q <= OCP_RUN;
      ocp_cnt_q   <= {`SLLC_CNT_W{1'b0}};
    end else begin
      ocp_state_q <= ocp_state_d;
      ocp_cnt_q   <= ocp_cnt_d;
    end
  end

  // Protection shutdowns override the enable pin for all channels
  assign shutdown    = logic_rst | ocp_shut | ot_s;
  assign drive_allow = oe_s & ~shutdown;

  genvar ch;
  generate
    for (ch = 0; ch < `SLLC_CHANNELS; ch = ch + 1) begin : g_drive
      // Only a driven channel can carry overcurrent
      assign oc_hit[ch] = oc_s[ch] & drive_q[ch];
      always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          drive_q[ch] <= 1'b0;
        end else begin
          drive_q[ch] <= latch_q[ch] & drive_allow;
        end
      end
    end
  endgenerate

  assign drive_output = drive_q;

  // Undervoltage is handled as a reset, not reported as a fault
  always @* begin
    fault_oe_d = 1'b0;
    if (!uv_s && (ocp_shut || ot_s)) begin
      fault_oe_d = 1'b1;
    end
  end

  // Fault flag is a level: low while overcurrent shutdown or over-temperature lasts
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fault_flag_n_o  <= 1'b0;
      fault_flag_n_oe <= 1'b0;
    end else begin
      fault_flag_n_o  <= 1'b0;
      fault_flag_n_oe <= fault_oe_d;
    end
  end

endmodule // sllc_top

//--- tb/sllc_checker.sv
// Purpose: Assertions on the pins of sllc_top
// Assumes: Pin inputs need four clocks to pass the input filter
// Notes:   Bound to every sllc_top instance
`timescale 1ns/1ps
`include "sllc_consts.vh"
module sllc_checker #(
  parameter [`SLLC_CNT_W-1:0] RETRY_CYCLES = `SLLC_OCP_RETRY_CYC
) (
  input logic       clock,
  input logic       rstn,
  input logic       chip_select_n,
  input logic       reset_pin,
  input logic       output_enable_pin,
  input logic [7:0] overcurrent_trip,
  input logic       over_temp,
  input logic       undervoltage_lock,
  input logic       serial_data_out_o,
  input logic       serial_data_out_oe,
  input logic       fault_flag_n_o,
  input logic       fault_flag_n_oe,
  input logic [7:0] drive_output
);
  logic [8:0]  oc_cnt_q;
  logic [7:0]  oc_mask_q;
  logic [17:0] shut_cnt_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Length of the current overcurrent run, drives seen at its start, and time the fault has stood
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      oc_cnt_q   <= 9'h000;
      oc_mask_q  <= 8'h00;
      shut_cnt_q <= 18'h0_0000;
    end else begin
      oc_cnt_q   <= (|overcurrent_trip && oc_cnt_q != 9'h1ff) ? oc_cnt_q + 9'h001 : 9'h000;
      oc_mask_q  <= (oc_cnt_q == 9'h000) ? drive_output : oc_mask_q;
      shut_cnt_q <= (fault_flag_n_oe && !over_temp && shut_cnt_q != 18'h3_ffff) ? shut_cnt_q + 18'h0_0001 : 18'h0_0000;
    end
  end
  sequence s_oe_off;
    !output_enable_pin [*8];
  endsequence
  sequence s_shifting;
    (!chip_select_n && output_enable_pin) [*8];
  endsequence
  oe_off_a: assert property (s_oe_off |-> drive_output == 8'h00) else $error("drive on while disabled");
  hold_reset_a: assert property (reset_pin [*8] |-> drive_output == 8'h00 && !serial_data_out_oe)
    else $error("activity during logic reset");
  uv_off_a: assert property (undervoltage_lock [*8] |-> drive_output == 8'h00 && !fault_flag_n_oe && !serial_data_out_oe)
    else $error("activity during undervoltage");
  ot_fault_a: assert property (over_temp [*8] |-> fault_flag_n_oe && drive_output == 8'h00)
    else $error("over temperature not handled");
  cs_release_a: assert property (chip_select_n [*8] |-> !serial_data_out_oe) else $error("serial out held");
  shift_hold_a: assert property (s_shifting |=> $stable(drive_output)) else $error("drives moved in shift");
  oc_early_a: assert property (oc_cnt_q == 9'h154 && |(overcurrent_trip & oc_mask_q) |->
    (drive_output & oc_mask_q) == oc_mask_q) else $error("overcurrent shut too early");
  oc_shut_a: assert property (oc_cnt_q == 9'h16d && |(overcurrent_trip & oc_mask_q) |->
    drive_output == 8'h00 && fault_flag_n_oe) else $error("overcurrent not shut");
  retry_time_a: assert property (fault_flag_n_oe && !over_temp |-> shut_cnt_q <= RETRY_CYCLES + 8)
    else $error("no retry after shutdown");
  open_drain_a: assert property (serial_data_out_o == 1'b0 && fault_flag_n_o == 1'b0)
    else $error("open drain pin driven high");
endmodule // sllc_checker
bind sllc_top sllc_checker #(.RETRY_CYCLES(RETRY_CYCLES)) u_chk (.clock, .rstn, .chip_select_n, .reset_pin,
  .output_enable_pin, .overcurrent_trip, .over_temp, .undervoltage_lock, .serial_data_out_o,
  .serial_data_out_oe, .fault_flag_n_o, .fault_flag_n_oe, .drive_output);

//--- tb/sllc_host.sv
// Purpose: Host side of the serial link: shift, select and latch pins
// Assumes: Shift clock half period of eight system clocks, 160 ns period
// Notes:   Serial out is read on its pulled-up line level
`timescale 1ns/1ps
module sllc_host (
  input  logic clock,
  input  logic sdo_level,
  output logic shift_clock,
  output logic serial_data_in,
  output logic chip_select_n,
  output logic latch_pin
);
  initial begin
    shift_clock = 1'b0;
    serial_data_in = 1'b0;
    chip_select_n = 1'b1;
    latch_pin = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Clock stands still outside frames; data line toggles after the last bit, before release
  task automatic xfer(input logic [15:0] data, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    chip_select_n <= 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_data_in <= data[i];
      tick(8);
      rx[i] = sdo_level;
      shift_clock <= 1'b1;
      tick(8);
      shift_clock <= 1'b0;
    end
    serial_data_in <= ~data[0];
    tick(8);
    chip_select_n <= 1'b1;
    tick(8);
    latch_pin <= 1'b1;
    tick(8);
    latch_pin <= 1'b0;
    tick(8);
  endtask
endmodule // sllc_host

//--- tb/test_serial_latched_lowside_control.sv
// Purpose: Self-checking bench of sllc_top
// Assumes: Short retry count for simulation
// Notes:   Open-drain pins modelled with pull-ups, enable pin with pull-down
`timescale 1ns/1ps
module test_serial_latched_lowside_control;
  localparam int RETRY = 50;
  logic        clock = 1'b0;
  logic        rstn, reset_pin, oe_q, oe_en, over_temp, undervoltage_lock;
  logic [7:0]  overcurrent_trip, drive_output, prev, w, b;
  logic        shift_clock, serial_data_in, chip_select_n, latch_pin, sdo_o, sdo_oe, flt_o, flt_oe;
  logic [15:0] rx;
  logic [31:0] seed = 32'h6e2f_3f60;
  int          miscompares = 0;
  int          cmp_count = 0;
  tri0         output_enable_pin;
  wire         sdo_level = !sdo_oe;
  wire         flt_level = !flt_oe;
  assign output_enable_pin = oe_en ? oe_q : 1'bz;
  always #5 clock = ~clock;
  sllc_top #(.RETRY_CYCLES(RETRY)) i_dut (.clock(clock), .rstn(rstn), .shift_clock(shift_clock),
    .serial_data_in(serial_data_in), .chip_select_n(chip_select_n), .latch_pin(latch_pin),
    .reset_pin(reset_pin), .output_enable_pin(output_enable_pin), .overcurrent_trip(overcurrent_trip),
    .over_temp(over_temp), .undervoltage_lock(undervoltage_lock), .serial_data_out_i(sdo_level),
    .serial_data_out_o(sdo_o), .serial_data_out_oe(sdo_oe), .fault_flag_n_i(flt_level),
    .fault_flag_n_o(flt_o), .fault_flag_n_oe(flt_oe), .drive_output(drive_output));
  sllc_host i_host (.clock(clock), .sdo_level(sdo_level), .shift_clock(shift_clock),
    .serial_data_in(serial_data_in), .chip_select_n(chip_select_n), .latch_pin(latch_pin));
  function automatic logic [7:0] rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [15:0] exp_pins(input logic [7:0] word, input logic on, input logic flt);
    return {7'h00, flt, on ? word : 8'h00};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pins(input logic [7:0] word, input logic on, input logic flt);
    chk({7'h00, flt_oe, drive_output}, exp_pins(word, on, flt));
  endtask
  task automatic end_of_test;
    $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clock);
    miscompares++;
    end_of_test();
  end
  initial begin
    rstn = 1'b0;
    reset_pin = 1'b0;
    oe_q = 1'b1;
    oe_en = 1'b1;
    over_temp = 1'b0;
    undervoltage_lock = 1'b0;
    overcurrent_trip = 8'h00;
    prev = 8'h00;
    tick(5);
    rstn <= 1'b1;
    tick(10);
    for (int k = 0; k < 8; k++) begin
      w = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : rnd8();
      i_host.xfer({8'h00, w}, 8, rx);
      chk(rx, {8'h00, prev});
      chk_pins(w, 1'b1, 1'b0);
      chk({15'h0000, sdo_level}, 16'h0001);
      prev = w;
    end
    w = rnd8();
    b = rnd8();
    i_host.xfer({w, b}, 16, rx);
    chk(rx, {prev, w});
    chk_pins(b, 1'b1, 1'b0);
    oe_q <= 1'b0;
    tick(10);
    chk_pins(b, 1'b0, 1'b0);
    oe_en <= 1'b0;
    oe_q <= 1'b1;
    w = rnd8() | 8'h01;
    i_host.xfer({8'h00, w}, 8, rx);
    chk_pins(w, 1'b0, 1'b0);
    oe_en <= 1'b1;
    tick(10);
    chk_pins(w, 1'b1, 1'b0);
    over_temp <= 1'b1;
    tick(10);
    chk_pins(w, 1'b0, 1'b1);
    over_temp <= 1'b0;
    tick(10);
    chk_pins(w, 1'b1, 1'b0);
    overcurrent_trip <= w;
    tick(340);
    chk_pins(w, 1'b1, 1'b0);
    tick(30);
    chk_pins(w, 1'b0, 1'b1);
    overcurrent_trip <= 8'h00;
    tick(RETRY + 20);
    chk_pins(w, 1'b1, 1'b0);
    reset_pin <= 1'b1;
    tick(10);
    chk_pins(w, 1'b0, 1'b0);
    i_host.xfer(16'h00a5, 8, rx);
    chk(rx, 16'h00ff);
    reset_pin <= 1'b0;
    tick(10);
    w = rnd8();
    i_host.xfer({8'h00, w}, 8, rx);
    chk(rx, 16'h0000);
    chk_pins(w, 1'b1, 1'b0);
    undervoltage_lock <= 1'b1;
    tick(10);
    chk_pins(w, 1'b0, 1'b0);
    undervoltage_lock <= 1'b0;
    tick(10);
    i_host.xfer({8'h00, rnd8()}, 8, rx);
    chk(rx, 16'h0000);
    end_of_test();
  end
endmodule // test_serial_latched_lowside_control
